// ### pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes the pins are level signals from outside the clock domain.
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic             clockEnable,
   input  wire logic [WIDTH-1:0] pinIn,
   output      logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_r;

   // ***************************************************
   // Stage one feeds stage two only
   // ***************************************************
   always_ff @(posedge clock) begin
      if (reset) begin
         stage1_r <= '0;
         syncOut  <= '0;
      end else if (clockEnable) begin
         stage1_r <= pinIn;
         syncOut  <= stage1_r;
      end
   end
endmodule

// ### port_pad_model.sv
// Far-side model of the port pads: external devices and pull resistors.
// Assumes index 0 is port 0, 1 is port 2, 2 is port 3.
`timescale 1ns/10ps

module port_pad_model (
   input  wire logic [2:0][7:0] devOut,
   input  wire logic [2:0][7:0] devEn,
   input  wire logic [2:0][7:0] extEn,
   input  wire logic [2:0][7:0] extVal,
   output      logic [2:0][7:0] pad
);

   // ************************************************
   // Pad resolution
   // ************************************************
   // The device wins over an external driver, so a test never sees
   // contention settled by the simulator.
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         for (int b = 0; b < 8; b++) begin
            if (devEn[p][b]) begin
               pad[p][b] = devOut[p][b];
            end else if (extEn[p][b]) begin
               pad[p][b] = extVal[p][b];
            end else begin
               // A released line is held high by its resistor
               pad[p][b] = 1'b1;
            end
         end
      end
   end

endmodule

// ### quad_parallel_io_ports.sv
// Four 8-bit parallel port units with their latch registers.
// Assumes a core that accesses registers with one-cycle strobes and
// that the pad ring resolves pins from output value and enable.
`timescale 1ns/10ps
module quad_parallel_io_ports
   import quad_port_pkg::*;
#(
   parameter int WIDTH = PORT_WIDTH
) (
   input  wire logic                          clock,
   input  wire logic                          reset,
   input  wire logic                          clockEnable,
   input  wire quad_port_pkg::sfr_req_t       sfrReq,
   output      logic [7:0]                    sfrRdata,
   output      logic                          sfrHit,
   input  wire quad_port_pkg::xmem_req_t      xmemReq,
   input  wire quad_port_pkg::alt_out_t       altOut,
   input  wire logic                          serialMode0,
   input  wire logic                          serialEnable,
   input  wire logic                          xdataEnable,
   output      quad_port_pkg::alt_in_t        altIn,
   output      logic [WIDTH-1:0]              xmemRdata,
   input  wire logic [WIDTH-1:0]              port0In,
   output      logic [WIDTH-1:0]              port0Out,
   output      logic [WIDTH-1:0]              port0OutEn,
   input  wire logic [WIDTH-1:0]              port1In,
   output      logic [WIDTH-1:0]              port1AnalogSel,
   input  wire logic [WIDTH-1:0]              port2In,
   output      logic [WIDTH-1:0]              port2Out,
   output      logic [WIDTH-1:0]              port2OutEn,
   input  wire logic [WIDTH-1:0]              port3In,
   output      logic [WIDTH-1:0]              port3Out,
   output      logic [WIDTH-1:0]              port3OutEn
);
   import quad_port_pkg::*;

   logic [WIDTH-1:0] port0_latch_r;
   logic [WIDTH-1:0] port1_config_r;
   logic [WIDTH-1:0] port2_latch_r;
   logic [WIDTH-1:0] port3_latch_r;
   logic [WIDTH-1:0] port0Sync;
   logic [WIDTH-1:0] port1Sync;
   logic [WIDTH-1:0] port2Sync;
   logic [WIDTH-1:0] port3Sync;
   logic [WIDTH-1:0] port0Out_nxt;
   logic [WIDTH-1:0] port0OutEn_nxt;
   logic [WIDTH-1:0] port2Out_nxt;
   logic [WIDTH-1:0] port2OutEn_nxt;
   logic [WIDTH-1:0] port3Out_nxt;
   logic [WIDTH-1:0] port3OutEn_nxt;
   logic [WIDTH-1:0] port3Drive;
   logic [WIDTH-1:0] port3Own;
   logic [WIDTH-1:0] p1Digital;
   logic [7:0]       sfrRdata_nxt;
   logic             p0Bus;

   // ***************************************************
   // Synchronisers for all pin inputs
   // ***************************************************
   pin_sync #(.WIDTH(4*WIDTH)) u_sync (
      .clock       (clock),
      .reset       (reset),
      .clockEnable (clockEnable),
      .pinIn       ({port3In, port2In, port1In, port0In}),
      .syncOut     ({port3Sync, port2Sync, port1Sync, port0Sync})
   );

   function automatic logic isAddr(input sfr_req_t r,
                                   input logic [7:0] a);
      return r.addr == a;
   endfunction

   // ***************************************************
   // Latch registers
   // ***************************************************
   always_ff @(posedge clock) begin
      if (reset) begin
         port0_latch_r  <= LATCH_RESET;
         port1_config_r <= LATCH_RESET;
         port2_latch_r  <= LATCH_RESET;
         port3_latch_r  <= LATCH_RESET;
      end else if (clockEnable && sfrReq.write) begin
         if (isAddr(sfrReq, ADDR_PORT0))
            port0_latch_r <= sfrReq.wdata[WIDTH-1:0];
         if (isAddr(sfrReq, ADDR_PORT1))
            port1_config_r <= sfrReq.wdata[WIDTH-1:0];
         if (isAddr(sfrReq, ADDR_PORT2))
            port2_latch_r <= sfrReq.wdata[WIDTH-1:0];
         if (isAddr(sfrReq, ADDR_PORT3))
            port3_latch_r <= sfrReq.wdata[WIDTH-1:0];
      end
   end

   // ***************************************************
   // Pin drive
   // ***************************************************
   // Port 3 pins whose peripheral is active; disabled ones stay GPIO
   always_comb begin
      port3Own = '0;
      port3Own[P3_SERIAL_RX]    = serialEnable && serialMode0
                                  && altOut.serialRxOutEn;
      port3Own[P3_SERIAL_TX]    = serialEnable;
      port3Own[P3_WRITE_STROBE] = xdataEnable;
      port3Own[P3_READ_STROBE]  = xdataEnable;
   end

   always_comb begin
      port3Drive = port3_latch_r;
      port3Drive[P3_SERIAL_RX]    = altOut.serialRxOut;
      port3Drive[P3_SERIAL_TX]    = altOut.serialTxOut;
      port3Drive[P3_WRITE_STROBE] = altOut.writeStrobeN;
      port3Drive[P3_READ_STROBE]  = altOut.readStrobeN;
   end

   assign p0Bus = xmemReq.addrPhase | xmemReq.dataOut;

   always_comb begin
      // Open drain: only zeros are driven from the latch
      port0Out_nxt   = '0;
      port0OutEn_nxt = ~port0_latch_r;
      if (p0Bus) begin
         // Bus mode drives both levels strongly
         port0Out_nxt   = xmemReq.addrPhase ? xmemReq.lowAddr
                                            : xmemReq.wdata;
         port0OutEn_nxt = '1;
      end
      // Pull-up ports: outside bus and peripheral use the enable models the strong low driver only
      port2Out_nxt   = xmemReq.hiActive ? xmemReq.hiAddr
                                        : port2_latch_r;
      port2OutEn_nxt = xmemReq.hiActive ? '1 : ~port2_latch_r;
      // Alternate output only passes while the latch holds one
      port3Out_nxt   = (port3Own & port3Drive & port3_latch_r)
                     | (~port3Own & port3_latch_r);
      // Owned pins drive strongly; a latch zero always pulls low
      port3OutEn_nxt = port3Own | ~port3_latch_r;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         port0Out   <= '0;
         port0OutEn <= '0;
         port2Out   <= LATCH_RESET;
         port2OutEn <= '0;
         port3Out   <= LATCH_RESET;
         port3OutEn <= '0;
      end else if (clockEnable) begin
         port0Out   <= port0Out_nxt;
         port0OutEn <= port0OutEn_nxt;
         port2Out   <= port2Out_nxt;
         port2OutEn <= port2OutEn_nxt;
         port3Out   <= port3Out_nxt;
         port3OutEn <= port3OutEn_nxt;
      end
   end

   // Port 1 has no output drive at all, only the analog selection
   always_ff @(posedge clock) begin
      if (reset)
         port1AnalogSel <= LATCH_RESET;
      else if (clockEnable)
         port1AnalogSel <= port1_config_r;
   end

   // ***************************************************
   // Alternate inputs to peripherals
   // ***************************************************
   // Digital path is live only where the pin is not in analog use
   assign p1Digital = port1Sync & ~port1_config_r;

   always_ff @(posedge clock) begin
      if (reset) begin
         altIn     <= '0;
         xmemRdata <= '0;
      end else if (clockEnable) begin
         // A latch zero pins the alternate input at zero
         altIn.timerCCountIn   <= port1Sync[P1_TIMER_C_COUNT]
                                & port1_config_r[P1_TIMER_C_COUNT];
         altIn.timerCTriggerIn <= port1Sync[P1_TIMER_C_TRIG]
                                & port1_config_r[P1_TIMER_C_TRIG];
         altIn.slaveSelectN    <= port1Sync[P1_SLAVE_SELECT]
                                & port1_config_r[P1_SLAVE_SELECT];
         altIn.serialRxIn      <= port3Sync[P3_SERIAL_RX]
                                & port3_latch_r[P3_SERIAL_RX];
         altIn.extIrqA         <= port3Sync[P3_EXT_IRQ_A]
                                & port3_latch_r[P3_EXT_IRQ_A];
         altIn.extIrqB         <= port3Sync[P3_EXT_IRQ_B]
                                & port3_latch_r[P3_EXT_IRQ_B];
         altIn.timerACountIn   <= port3Sync[P3_TIMER_A_COUNT]
                                & port3_latch_r[P3_TIMER_A_COUNT];
         altIn.timerBCountIn   <= port3Sync[P3_TIMER_B_COUNT]
                                & port3_latch_r[P3_TIMER_B_COUNT];
         xmemRdata             <= port0Sync;
      end
   end

   // ***************************************************
   // Register read
   // ***************************************************
   // Reads return pin state, zero for port 1 analog pins, as a port read does on this core
   always_comb begin
      sfrRdata_nxt = BYTE_ZERO;
      if (isAddr(sfrReq, ADDR_PORT0))
         sfrRdata_nxt = port0Sync;
      else if (isAddr(sfrReq, ADDR_PORT1))
         sfrRdata_nxt = p1Digital;
      else if (isAddr(sfrReq, ADDR_PORT2))
         sfrRdata_nxt = port2Sync;
      else if (isAddr(sfrReq, ADDR_PORT3))
         sfrRdata_nxt = port3Sync;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         sfrRdata <= BYTE_ZERO;
         sfrHit   <= 1'b0;
      end else if (clockEnable) begin
         sfrRdata <= sfrReq.read ? sfrRdata_nxt : BYTE_ZERO;
         sfrHit   <= sfrReq.read && (isAddr(sfrReq, ADDR_PORT0)
                     || isAddr(sfrReq, ADDR_PORT1)
                     || isAddr(sfrReq, ADDR_PORT2)
                     || isAddr(sfrReq, ADDR_PORT3));
      end
   end

   // ***************************************************
   // Assertions
   // ***************************************************
   property p_p0_float;
      @(posedge clock) disable iff (reset)
      (clockEnable && !p0Bus && port0_latch_r == '1)
         |=> (port0OutEn == '0);
   endproperty
   a_p0_float: assert property (p_p0_float)
      else $error("port 0 drives a pin whose latch is one");

   property p_p0_bus;
      @(posedge clock) disable iff (reset)
      (clockEnable && xmemReq.addrPhase)
         |=> (port0OutEn == '1 && port0Out == $past(xmemReq.lowAddr));
   endproperty
   a_p0_bus: assert property (p_p0_bus)
      else $error("port 0 does not drive the low address");

   property p_p1_write;
      @(posedge clock) disable iff (reset)
      (clockEnable && sfrReq.write && sfrReq.addr == ADDR_PORT1)
         |=> ##1 (!$past(clockEnable)
                  || port1AnalogSel == $past(sfrReq.wdata, 2));
   endproperty
   a_p1_write: assert property (p_p1_write)
      else $error("port 1 analog selection did not follow write");

   property p_p2_addr;
      @(posedge clock) disable iff (reset)
      (clockEnable && xmemReq.hiActive)
         |=> (port2Out == $past(xmemReq.hiAddr) && port2OutEn == '1);
   endproperty
   a_p2_addr: assert property (p_p2_addr)
      else $error("port 2 does not drive the upper address");

   property p_p2_pullup;
      @(posedge clock) disable iff (reset)
      (clockEnable && !xmemReq.hiActive)
         |=> (port2OutEn == ~$past(port2_latch_r));
   endproperty
   a_p2_pullup: assert property (p_p2_pullup)
      else $error("port 2 driver does not match the latch");

   property p_p3_stuck;
      @(posedge clock) disable iff (reset)
      (clockEnable && !port3_latch_r[P3_SERIAL_TX])
         |=> (!port3Out[P3_SERIAL_TX] && port3OutEn[P3_SERIAL_TX]);
   endproperty
   a_p3_stuck: assert property (p_p3_stuck)
      else $error("transmit pin not held low with latch zero");

   property p_p3_tx;
      @(posedge clock) disable iff (reset)
      (clockEnable && serialEnable && port3_latch_r[P3_SERIAL_TX])
         |=> (port3Out[P3_SERIAL_TX] == $past(altOut.serialTxOut));
   endproperty
   a_p3_tx: assert property (p_p3_tx)
      else $error("transmit pin does not follow the serial output");

   property p_irq_gate;
      @(posedge clock) disable iff (reset)
      (clockEnable && !port3_latch_r[P3_EXT_IRQ_A])
         |=> !altIn.extIrqA;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt input passed with latch zero");

   property p_reset_ones;
      @(posedge clock) $fell(reset) |-> (port0_latch_r == LATCH_RESET
         && port2_latch_r == LATCH_RESET && port3_latch_r == LATCH_RESET);
   endproperty
   a_reset_ones: assert property (p_reset_ones)
      else $error("latches not all ones after reset");

   property p_p0_data;
      @(posedge clock) disable iff (reset)
      (clockEnable && xmemReq.dataOut && !xmemReq.addrPhase)
         |=> (port0OutEn == '1 && port0Out == $past(xmemReq.wdata));
   endproperty
   a_p0_data: assert property (p_p0_data)
      else $error("port 0 does not drive the write data");

   property p_rx_mode0;
      @(posedge clock) disable iff (reset)
      (clockEnable && serialEnable && serialMode0 && altOut.serialRxOutEn
         && port3_latch_r[P3_SERIAL_RX])
         |=> (port3OutEn[P3_SERIAL_RX]
         && port3Out[P3_SERIAL_RX] == $past(altOut.serialRxOut));
   endproperty
   a_rx_mode0: assert property (p_rx_mode0)
      else $error("receive pin does not carry mode 0 data");

   property p_strobe;
      @(posedge clock) disable iff (reset)
      (clockEnable && xdataEnable && port3_latch_r[P3_WRITE_STROBE])
         |=> (port3OutEn[P3_WRITE_STROBE]
         && port3Out[P3_WRITE_STROBE] == $past(altOut.writeStrobeN));
   endproperty
   a_strobe: assert property (p_strobe)
      else $error("write strobe pin does not follow the strobe");

   // A latch zero holds every port 3 pin low, owned or not
   property p_p3_gate;
      @(posedge clock) disable iff (reset)
      clockEnable |=> ((port3Out & ~$past(port3_latch_r)) == '0);
   endproperty
   a_p3_gate: assert property (p_p3_gate)
      else $error("port 3 pin high while its latch holds zero");

   property p_sfr_hit;
      @(posedge clock) disable iff (reset)
      (clockEnable && sfrReq.read && sfrReq.addr == ADDR_PORT0)
         |=> (sfrHit && sfrRdata == $past(port0Sync));
   endproperty
   a_sfr_hit: assert property (p_sfr_hit)
      else $error("port 0 read not answered with the pin levels");

   c_p0_bus:  cover property (@(posedge clock) xmemReq.addrPhase);
   c_p1_dig:  cover property (@(posedge clock) port1_config_r != '1);
   c_p3_ser:  cover property (@(posedge clock) serialEnable && serialMode0);
   c_xdata:   cover property (@(posedge clock) xdataEnable);
endmodule

// ### quad_parallel_io_ports_test.sv
// Self-checking bench for the four parallel port units.
// Assumes the pad model resolves pins; inputs change at falling edges.
`timescale 1ns/10ps

module quad_parallel_io_ports_test;
   import quad_port_pkg::*;

   typedef struct {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] expRead;
      logic       expHit;
   } row_t;

   logic            clock;
   logic            reset;
   logic            clockEnable;
   sfr_req_t        sfrReq;
   logic [7:0]      sfrRdata;
   logic            sfrHit;
   xmem_req_t       xmemReq;
   alt_out_t        altOut;
   logic            serialMode0;
   logic            serialEnable;
   logic            xdataEnable;
   alt_in_t         altIn;
   logic [7:0]      xmemRdata;
   logic [7:0]      port1In;
   logic [7:0]      port1AnalogSel;
   logic [2:0][7:0] devOut;
   logic [2:0][7:0] devEn;
   logic [2:0][7:0] extEn;
   logic [2:0][7:0] extVal;
   logic [2:0][7:0] pad;
   logic [7:0]      rd;
   logic            hit;
   int              failCount;
   int              samplesChecked;

   row_t rows[10] = '{
      '{8'h80, 8'h3C, 8'h3C, 1'b1}, '{8'hA0, 8'h96, 8'h96, 1'b1},
      '{8'hB0, 8'h5A, 8'h5A, 1'b1}, '{8'h90, 8'h0F, 8'hA0, 1'b1},
      '{8'h90, 8'hF0, 8'h05, 1'b1}, '{8'h81, 8'h77, 8'h00, 1'b0},
      '{8'h80, 8'hFF, 8'hFF, 1'b1}, '{8'hA0, 8'hFF, 8'hFF, 1'b1},
      '{8'hB0, 8'hFF, 8'hFF, 1'b1}, '{8'h90, 8'hFF, 8'h00, 1'b1}};

   quad_parallel_io_ports quad_parallel_io_ports_inst (
      .clock(clock), .reset(reset), .clockEnable(clockEnable),
      .sfrReq(sfrReq), .sfrRdata(sfrRdata), .sfrHit(sfrHit),
      .xmemReq(xmemReq), .altOut(altOut), .serialMode0(serialMode0),
      .serialEnable(serialEnable), .xdataEnable(xdataEnable),
      .altIn(altIn), .xmemRdata(xmemRdata),
      .port0In(pad[0]), .port0Out(devOut[0]), .port0OutEn(devEn[0]),
      .port1In(port1In), .port1AnalogSel(port1AnalogSel),
      .port2In(pad[1]), .port2Out(devOut[1]), .port2OutEn(devEn[1]),
      .port3In(pad[2]), .port3Out(devOut[2]), .port3OutEn(devEn[2]));

   port_pad_model port_pad_model_inst (
      .devOut(devOut), .devEn(devEn), .extEn(extEn), .extVal(extVal),
      .pad(pad));

   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
      samplesChecked++;
      if (got !== exp) begin
         failCount++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic sfrWrite(logic [7:0] a, logic [7:0] d);
      @(negedge clock);
      sfrReq = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
      @(negedge clock);
      sfrReq.write = 1'b0;
   endtask

   // Read data stands for one cycle, so it is taken at the next fall
   task automatic sfrRead(logic [7:0] a, output logic [7:0] d,
                          output logic h);
      @(negedge clock);
      sfrReq = '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clock);
      d = sfrRdata;
      h = sfrHit;
      sfrReq.read = 1'b0;
   endtask

   task automatic pulseReset();
      @(negedge clock);
      reset = 1'b1;
      repeat (2) @(negedge clock);
      reset = 1'b0;
   endtask

   task automatic checkResetState();
      chk("pad0 rst", 8'hFF, pad[0]);
      chk("pad2 rst", 8'hFF, pad[1]);
      chk("pad3 rst", 8'hFF, pad[2]);
      chk("p0 en rst", 8'h00, devEn[0]);
      chk("analog rst", 8'hFF, port1AnalogSel);
   endtask

   task automatic tallyAndFinish();
      if (failCount == 0 && samplesChecked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ************************************************
   // Clock and watchdog
   // ************************************************
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   initial begin
      repeat (5000) @(posedge clock);
      failCount++;
      tallyAndFinish();
   end

   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      failCount = 0;
      samplesChecked = 0;
      reset = 1'b1;
      clockEnable = 1'b1;
      sfrReq = '0;
      xmemReq = '0;
      altOut = '{serialTxOut: 1'b1, serialRxOut: 1'b1, serialRxOutEn: 1'b0,
                 writeStrobeN: 1'b1, readStrobeN: 1'b1};
      serialMode0 = 1'b0;
      serialEnable = 1'b0;
      xdataEnable = 1'b0;
      port1In = 8'hA5;
      extEn = '0;
      extVal = '0;
      repeat (2) @(negedge clock);
      reset = 1'b0;
      checkResetState();
      foreach (rows[i]) begin
         sfrWrite(rows[i].addr, rows[i].wdata);
         repeat (3) @(negedge clock);
         sfrRead(rows[i].addr, rd, hit);
         chk("read", rows[i].expRead, rd);
         chk("hit", {7'h00, rows[i].expHit}, {7'h00, hit});
         case (rows[i].addr)
            ADDR_PORT0: begin
               chk("pad0", rows[i].wdata, pad[0]);
               chk("p0 en", 8'h00, devEn[0] & rows[i].wdata);
            end
            ADDR_PORT1: begin
               chk("analog", rows[i].wdata, port1AnalogSel);
            end
            ADDR_PORT2: chk("pad2", rows[i].wdata, pad[1]);
            ADDR_PORT3: chk("pad3", rows[i].wdata, pad[2]);
            default: chk("pad2 kept", 8'h96, pad[1]);
         endcase
      end
      // External bus: address, write data, then a read of the pins
      xmemReq = '{1'b1, 1'b0, 1'b1, 8'h5A, 8'hC3, 8'h00};
      repeat (2) @(negedge clock);
      chk("bus low", 8'h5A, pad[0]);
      chk("bus en", 8'hFF, devEn[0]);
      chk("bus high", 8'hC3, pad[1]);
      chk("high en", 8'hFF, devEn[1]);
      xmemReq = '{1'b0, 1'b1, 1'b1, 8'h5A, 8'h3E, 8'hA6};
      repeat (2) @(negedge clock);
      chk("bus data", 8'hA6, pad[0]);
      chk("bus mid", 8'h3E, pad[1]);
      xmemReq = '0;
      extEn[0] = 8'hFF;
      extVal[0] = 8'hC9;
      repeat (4) @(negedge clock);
      chk("bus rdata", 8'hC9, xmemRdata);
      chk("p0 free", 8'h00, devEn[0]);
      chk("p2 back", 8'hFF, pad[1]);
      // Peripheral inputs on ports 1 and 3
      extEn = '0;
      extEn[2] = 8'hFF;
      extVal[2] = 8'h14;
      port1In = 8'h23;
      repeat (4) @(negedge clock);
      chk("alt in", 8'hEA, altIn);
      sfrWrite(ADDR_PORT1, 8'h00);
      repeat (5) @(negedge clock);
      chk("alt gated", 8'h0A, altIn);
      // Peripheral outputs on port 3 and their latch gating
      extEn = '0;
      serialEnable = 1'b1;
      xdataEnable = 1'b1;
      altOut.serialTxOut = 1'b0;
      altOut.writeStrobeN = 1'b0;
      repeat (3) @(negedge clock);
      chk("alt out", 8'hBD, pad[2]);
      sfrWrite(ADDR_PORT3, 8'h7F);
      repeat (3) @(negedge clock);
      chk("alt stuck", 8'h3D, pad[2]);
      altOut.writeStrobeN = 1'b1;
      repeat (3) @(negedge clock);
      chk("strobe idle", 8'h7D, pad[2]);
      // Mode 0 data out on the receive pin, then transmit held low
      serialMode0 = 1'b1;
      altOut.serialRxOutEn = 1'b1;
      altOut.serialRxOut = 1'b0;
      altOut.serialTxOut = 1'b1;
      repeat (3) @(negedge clock);
      chk("mode0 out", 8'h7E, pad[2]);
      sfrWrite(ADDR_PORT3, 8'h7D);
      repeat (3) @(negedge clock);
      chk("tx stuck", 8'h7C, pad[2]);
      serialMode0 = 1'b0;
      altOut.serialRxOutEn = 1'b0;
      // A frozen clock enable must ignore a write
      clockEnable = 1'b0;
      sfrWrite(ADDR_PORT2, 8'h00);
      clockEnable = 1'b1;
      repeat (3) @(negedge clock);
      chk("frozen", 8'hFF, pad[1]);
      // Reset in mid-run restores released latches
      sfrWrite(ADDR_PORT0, 8'h00);
      sfrWrite(ADDR_PORT2, 8'h00);
      @(negedge clock);
      chk("p0 low", 8'h00, pad[0]);
      chk("p2 low", 8'h00, pad[1]);
      serialEnable = 1'b0;
      xdataEnable = 1'b0;
      pulseReset();
      checkResetState();
      tallyAndFinish();
   end

endmodule

// ### quad_port_pkg.sv
// Shared constants and carrier types for the four parallel port units.
// Assumes an 8-bit special-function register access from the core.
package quad_port_pkg;

   localparam int PORT_WIDTH = 8;

   // Register addresses in the special-function space
   localparam logic [7:0] ADDR_PORT0 = 8'h80;
   localparam logic [7:0] ADDR_PORT1 = 8'h90;
   localparam logic [7:0] ADDR_PORT2 = 8'hA0;
   localparam logic [7:0] ADDR_PORT3 = 8'hB0;

   // Reset value of the latch registers, and the zero byte for read data
   localparam logic [7:0] LATCH_RESET = 8'hFF;
   localparam logic [7:0] BYTE_ZERO   = 8'h00;

   // Alternate function bit positions
   localparam int P1_TIMER_C_COUNT  = 0;
   localparam int P1_TIMER_C_TRIG   = 1;
   localparam int P1_SLAVE_SELECT   = 5;
   localparam int P3_SERIAL_RX      = 0;
   localparam int P3_SERIAL_TX      = 1;
   localparam int P3_EXT_IRQ_A      = 2;
   localparam int P3_EXT_IRQ_B      = 3;
   localparam int P3_TIMER_A_COUNT  = 4;
   localparam int P3_TIMER_B_COUNT  = 5;
   localparam int P3_WRITE_STROBE   = 6;
   localparam int P3_READ_STROBE    = 7;

   // Access from the core into the register space
   typedef struct packed {
      logic       write;
      logic       read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   // External memory bus request from the core
   typedef struct packed {
      logic       addrPhase;   // Port 0 carries the low address
      logic       dataOut;     // Port 0 drives write data
      logic       hiActive;    // Port 2 carries upper address
      logic [7:0] lowAddr;
      logic [7:0] hiAddr;
      logic [7:0] wdata;
   } xmem_req_t;

   // Peripheral outputs that may replace the port 3 latch value
   typedef struct packed {
      logic serialTxOut;
      logic serialRxOut;     // Mode 0 data driven out
      logic serialRxOutEn;
      logic writeStrobeN;
      logic readStrobeN;
   } alt_out_t;

   // Inputs delivered to the on-chip peripherals
   typedef struct packed {
      logic timerCCountIn;
      logic timerCTriggerIn;
      logic slaveSelectN;
      logic serialRxIn;
      logic extIrqA;
      logic extIrqB;
      logic timerACountIn;
      logic timerBCountIn;
   } alt_in_t;

endpackage
